//--- hdl/spc_map.svh
// Register map, field positions, reset values and the list of operating rules.
// ****************************************************************************
// Operation
// - Wall chosen whenever within 4.0V to 5.5V.
// - Wall chosen below 4.0V when highest source.
// - Unsuitable wall with USB present selects USB; the logic also needs USB highest.
// - Wall plus cell trickles; fast only when active.
// - Slave role default; master only by bit.
// - Slave takes USB when wall bad, USB highest.
// - Off to active on USB needs 4.0V.
// - USB capped 100mA or 500mA; config default.
// - Role picks which 500mA bit sets threshold.
// - Excess USB current limited and flag raised.
// - Override disables limit, doubles flag threshold.
// - Suitable wall during USB use takes over.
// - Low mode trickles, suspended to hold 100mA.
// - High mode trims fast charge within 500mA.
// - USB charging only allowed in slave role.
// - Disconnect bit opens switch, cell supplies.
// - Disconnect clears on reset, UVLO, boot fail.
// - Master bit clears on reset, master exit.
// - Over-current flag rises on edge, read clears.
// - Mask bit blocks flag from interrupt line.
// - Monitoring works in both USB roles.
// ****************************************************************************
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH

// ****************************************************************************
// Register indices; byte address is four times the index.
// ****************************************************************************
`define SPC_IDX_SYSTEM_CONTROL_TWO        6'h04
`define SPC_IDX_INTERRUPT_STATUS_TWO      6'h1A
`define SPC_IDX_INTERRUPT_STATUS_TWO_MASK 6'h22
`define SPC_IDX_CHARGE_CONTROL            6'h30
`define SPC_IDX_SUPPLY_STATUS             6'h31

// ****************************************************************************
// Field positions.
// ****************************************************************************
`define SPC_BIT_USB_DISCONNECT            14
`define SPC_BIT_HOST_ROLE                 13
`define SPC_BIT_HOST_HIGH                 11
`define SPC_BIT_DEVICE_HIGH               9
`define SPC_BIT_OVERCURRENT               10
`define SPC_BIT_FAST_REQUEST              0
`define SPC_BIT_LIMIT_OVERRIDE            1

// ****************************************************************************
// Reset values and counts.
// ****************************************************************************
`define SPC_RST_SYSTEM_CONTROL_TWO        16'h0000
`define SPC_RST_MASK                      16'h0000
`define SPC_RST_CHARGE_CONTROL            16'h0000
`define SPC_STRAP_WAIT                    2'h3

`endif

//--- hdl/spc_pkg.sv
// Types shared by the supply control block.
package spc_pkg;

  typedef enum logic [2:0] {
    SUP_CELL = 3'b001,
    SUP_WALL = 3'b010,
    SUP_USB  = 3'b100
  } spc_supply_t;

  typedef enum logic [1:0] {
    RESP_OKAY   = 2'h0,
    RESP_SLVERR = 2'h2
  } spc_resp_t;

endpackage

//--- hdl/spc_sync.sv
// Two-stage synchroniser for a vector of independent level inputs.
module spc_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         nrst,
  // Levels.
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_reg;

  initial begin
    if (W < 1) begin
      $error("spc_sync width must be at least one");
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_reg <= '0;
      dout     <= '0;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end

endmodule

//--- hdl/spc_top.sv
// Supply source selection and USB power control with an AXI4-Lite register port.
//
// The AXI4-Lite slave port is this design's own decision.
`include "spc_map.svh"

module spc_top #(
  parameter int ADDR_W  = 8,
  parameter int LEVEL_W = 4
) (
  // Clock and reset.
  input  wire logic               CLOCK,
  input  wire logic               NRST,
  // AXI4-Lite write address.
  input  wire logic [ADDR_W-1:0]  AWADDR,
  input  wire logic               AWVALID,
  output logic                    AWREADY,
  // AXI4-Lite write data.
  input  wire logic [31:0]        WDATA,
  input  wire logic [3:0]         WSTRB,
  input  wire logic               WVALID,
  output logic                    WREADY,
  // AXI4-Lite write response.
  output logic [1:0]              BRESP,
  output logic                    BVALID,
  input  wire logic               BREADY,
  // AXI4-Lite read address.
  input  wire logic [ADDR_W-1:0]  ARADDR,
  input  wire logic               ARVALID,
  output logic                    ARREADY,
  // AXI4-Lite read data.
  output logic [31:0]             RDATA,
  output logic [1:0]              RRESP,
  output logic                    RVALID,
  input  wire logic               RREADY,
  // Supply comparator levels.
  input  wire logic               WALL_IN_RANGE,
  input  wire logic               WALL_HIGHEST,
  input  wire logic               USB_PRESENT,
  input  wire logic               USB_HIGHEST,
  input  wire logic               USB_ABOVE_4V0,
  input  wire logic               CELL_SUPPLY_PIN_OK,
  input  wire logic               PREF_BELOW_UVLO,
  input  wire logic               BOOT_HYST_FAIL,
  // USB current comparator levels.
  input  wire logic               USB_OVER_100,
  input  wire logic               USB_OVER_200,
  input  wire logic               USB_OVER_500,
  input  wire logic               USB_OVER_1000,
  // Power state and straps.
  input  wire logic               USB_ROLE_DROP,
  input  wire logic               CONFIG_USB_HIGH,
  input  wire logic               STATE_ACTIVE,
  input  wire logic               WAKE_REQUEST,
  // Supply and charger controls.
  output logic                    SEL_WALL,
  output logic                    SEL_USB,
  output logic                    SEL_CELL,
  output logic                    USB_SWITCH_ON,
  output logic                    USB_SOURCING,
  output logic                    USB_LIMIT_ON,
  output logic                    USB_HIGH_MODE,
  output logic                    WAKE_PERMIT,
  output logic                    TRICKLE_EN,
  output logic                    FAST_EN,
  output logic [LEVEL_W-1:0]      FAST_LEVEL,
  // Interrupt.
  output logic                    USB_IRQ
);

  initial begin
    if (ADDR_W < 8 || ADDR_W > 32) begin
      $error("spc_top ADDR_W must be between 8 and 32");
    end
    if (LEVEL_W < 1 || LEVEL_W > 8) begin
      $error("spc_top LEVEL_W must be between 1 and 8");
    end
  end

  // ****************************************************************************
  // Input synchronisers.
  // ****************************************************************************
  logic [15:0] pins_raw;
  logic [15:0] pins;

  assign pins_raw = {WAKE_REQUEST, STATE_ACTIVE, CONFIG_USB_HIGH, USB_ROLE_DROP,
                     USB_OVER_1000, USB_OVER_500, USB_OVER_200, USB_OVER_100,
                     BOOT_HYST_FAIL, PREF_BELOW_UVLO, CELL_SUPPLY_PIN_OK, USB_ABOVE_4V0,
                     USB_HIGHEST, USB_PRESENT, WALL_HIGHEST, WALL_IN_RANGE};

  spc_sync #(
    .W (16)
  ) u_sync (
    .clk  (CLOCK),
    .nrst (NRST),
    .din  (pins_raw),
    .dout (pins)
  );

  wire wall_in_range = pins[0];
  wire wall_highest  = pins[1];
  wire usb_present   = pins[2];
  wire usb_highest   = pins[3];
  wire usb_above_4v0 = pins[4];
  wire cell_ok       = pins[5];
  wire below_uvlo    = pins[6];
  wire boot_fail     = pins[7];
  wire over_100      = pins[8];
  wire over_200      = pins[9];
  wire over_500      = pins[10];
  wire over_1000     = pins[11];
  wire role_drop     = pins[12];
  wire cfg_high      = pins[13];
  wire state_active  = pins[14];
  wire wake_request  = pins[15];

  // ****************************************************************************
  // Register state.
  // ****************************************************************************
  logic [15:0]         ctrl_reg;
  logic [15:0]         mask_reg;
  logic [15:0]         chg_reg;
  logic                flag_reg;
  logic                over_prev_reg;
  logic [1:0]          strap_cnt_reg;
  logic                host_role_reg;
  spc_pkg::spc_supply_t supply_reg;
  spc_pkg::spc_supply_t supply_next;
  logic [LEVEL_W-1:0]  level_reg;

  wire usb_disconnect = ctrl_reg[`SPC_BIT_USB_DISCONNECT];
  wire host_role_bit  = ctrl_reg[`SPC_BIT_HOST_ROLE];
  wire host_high      = ctrl_reg[`SPC_BIT_HOST_HIGH];
  wire device_high    = ctrl_reg[`SPC_BIT_DEVICE_HIGH];
  wire fast_request   = chg_reg[`SPC_BIT_FAST_REQUEST];
  wire limit_override = chg_reg[`SPC_BIT_LIMIT_OVERRIDE];
  wire flag_mask      = mask_reg[`SPC_BIT_OVERCURRENT];

  // ****************************************************************************
  // AXI4-Lite slave handshakes.
  // ****************************************************************************
  logic              aw_full_reg;
  logic              w_full_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;

  wire aw_take = AWVALID & AWREADY;
  wire w_take  = WVALID & WREADY;
  wire ar_take = ARVALID & ARREADY;
  wire do_write = aw_full_reg & w_full_reg & ~BVALID;

  wire [5:0] w_idx = aw_addr_reg[7:2];
  wire [5:0] r_idx = ARADDR[7:2];
  wire w_hi_zero = (ADDR_W > 8) ? (aw_addr_reg >> 8) == '0 : 1'b1;
  wire r_hi_zero = (ADDR_W > 8) ? (ARADDR >> 8) == '0 : 1'b1;

  wire w_ctrl = w_hi_zero & (w_idx == `SPC_IDX_SYSTEM_CONTROL_TWO);
  wire w_stat = w_hi_zero & (w_idx == `SPC_IDX_INTERRUPT_STATUS_TWO);
  wire w_mask = w_hi_zero & (w_idx == `SPC_IDX_INTERRUPT_STATUS_TWO_MASK);
  wire w_chg  = w_hi_zero & (w_idx == `SPC_IDX_CHARGE_CONTROL);
  wire w_sts  = w_hi_zero & (w_idx == `SPC_IDX_SUPPLY_STATUS);
  wire w_hit  = w_ctrl | w_stat | w_mask | w_chg | w_sts;

  wire r_ctrl = r_hi_zero & (r_idx == `SPC_IDX_SYSTEM_CONTROL_TWO);
  wire r_stat = r_hi_zero & (r_idx == `SPC_IDX_INTERRUPT_STATUS_TWO);
  wire r_mask = r_hi_zero & (r_idx == `SPC_IDX_INTERRUPT_STATUS_TWO_MASK);
  wire r_chg  = r_hi_zero & (r_idx == `SPC_IDX_CHARGE_CONTROL);
  wire r_sts  = r_hi_zero & (r_idx == `SPC_IDX_SUPPLY_STATUS);
  wire r_hit  = r_ctrl | r_stat | r_mask | r_chg | r_sts;

  // Only the low two byte lanes carry register bits.
  wire [15:0] lane_mask = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  wire [15:0] ctrl_wr   = (ctrl_reg & ~lane_mask) | (w_data_reg[15:0] & lane_mask);
  wire [15:0] mask_wr   = (mask_reg & ~lane_mask) | (w_data_reg[15:0] & lane_mask);
  wire [15:0] chg_wr    = (chg_reg & ~lane_mask) | (w_data_reg[15:0] & lane_mask);
  wire [15:0] ctrl_keep = 16'h4000 | 16'h2000 | 16'h0800 | 16'h0200;
  wire [15:0] chg_keep  = 16'h0003;

  wire [15:0] stat_view = 16'({flag_reg} << `SPC_BIT_OVERCURRENT);
  wire [15:0] sts_view  = {6'h00, level_reg[LEVEL_W-1:0] == '1, FAST_EN, TRICKLE_EN,
                           USB_LIMIT_ON, USB_HIGH_MODE, host_role_reg,
                           supply_reg[2], supply_reg[1], supply_reg[0], USB_IRQ};
  wire [15:0] r_word    = r_ctrl ? ctrl_reg :
                          r_stat ? stat_view :
                          r_mask ? mask_reg :
                          r_chg  ? chg_reg :
                          r_sts  ? sts_view : 16'h0000;

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      AWREADY     <= 1'b0;
      WREADY      <= 1'b0;
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      BVALID      <= 1'b0;
      BRESP       <= spc_pkg::RESP_OKAY;
    end else begin
      AWREADY <= AWVALID & ~AWREADY & ~aw_full_reg & ~BVALID;
      WREADY  <= WVALID & ~WREADY & ~w_full_reg & ~BVALID;
      if (aw_take) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= AWADDR;
      end else if (do_write) begin
        aw_full_reg <= 1'b0;
      end
      if (w_take) begin
        w_full_reg <= 1'b1;
        w_data_reg <= WDATA;
        w_strb_reg <= WSTRB;
      end else if (do_write) begin
        w_full_reg <= 1'b0;
      end
      if (do_write) begin
        BVALID <= 1'b1;
        BRESP  <= w_hit ? spc_pkg::RESP_OKAY : spc_pkg::RESP_SLVERR;
      end else if (BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= 32'h0000_0000;
      RRESP   <= spc_pkg::RESP_OKAY;
    end else begin
      ARREADY <= ARVALID & ~ARREADY & ~RVALID;
      if (ar_take) begin
        RVALID <= 1'b1;
        RDATA  <= {16'h0000, r_word};
        RRESP  <= r_hit ? spc_pkg::RESP_OKAY : spc_pkg::RESP_SLVERR;
      end else if (RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end

  // ****************************************************************************
  // Control registers.
  // ****************************************************************************
  wire role_exit = host_role_reg & role_drop;
  wire strap_now = strap_cnt_reg == `SPC_STRAP_WAIT;

  // Hardware clears are applied after the software write so they always win.
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      ctrl_reg      <= `SPC_RST_SYSTEM_CONTROL_TWO;
      mask_reg      <= `SPC_RST_MASK;
      chg_reg       <= `SPC_RST_CHARGE_CONTROL;
      strap_cnt_reg <= 2'h0;
    end else begin
      if (!strap_now) begin
        strap_cnt_reg <= strap_cnt_reg + 2'h1;
      end
      if (do_write && w_ctrl) begin
        ctrl_reg <= ctrl_wr & ctrl_keep;
      end
      if (do_write && w_mask) begin
        mask_reg <= mask_wr & (16'h0001 << `SPC_BIT_OVERCURRENT);
      end
      if (do_write && w_chg) begin
        chg_reg <= chg_wr & chg_keep;
      end
      // The strap is caught once the synchroniser has settled after release.
      if (strap_cnt_reg == `SPC_STRAP_WAIT - 2'h1) begin
        ctrl_reg[`SPC_BIT_DEVICE_HIGH] <= cfg_high;
      end
      if (below_uvlo || boot_fail) begin
        ctrl_reg[`SPC_BIT_USB_DISCONNECT] <= 1'b0;
        ctrl_reg[`SPC_BIT_DEVICE_HIGH]    <= 1'b0;
      end
      if (role_exit) begin
        ctrl_reg[`SPC_BIT_HOST_ROLE] <= 1'b0;
      end
    end
  end

  // ****************************************************************************
  // Role and supply selection.
  // ****************************************************************************
  wire wall_ok   = wall_in_range | wall_highest;
  wire usb_avail = usb_present & ~usb_disconnect & ~host_role_reg;
  wire high_mode = host_role_reg ? host_high : device_high;

  always_comb begin
    supply_next = spc_pkg::SUP_CELL;
    case (supply_reg)
      spc_pkg::SUP_WALL, spc_pkg::SUP_USB, spc_pkg::SUP_CELL: begin
        if (wall_ok) begin
          supply_next = spc_pkg::SUP_WALL;
        end else if (usb_avail && usb_highest) begin
          supply_next = spc_pkg::SUP_USB;
        end else begin
          supply_next = spc_pkg::SUP_CELL;
        end
      end
      default: begin
        supply_next = spc_pkg::SUP_CELL;
      end
    endcase
  end

  wire sel_usb_next  = supply_next == spc_pkg::SUP_USB;
  wire sel_wall_next = supply_next == spc_pkg::SUP_WALL;

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      supply_reg    <= spc_pkg::SUP_CELL;
      host_role_reg <= 1'b0;
    end else begin
      supply_reg <= supply_next;
      if (role_exit) begin
        host_role_reg <= 1'b0;
      end else if (host_role_bit) begin
        host_role_reg <= 1'b1;
      end
    end
  end

  // ****************************************************************************
  // Current monitoring and charging.
  // ****************************************************************************
  // Monitoring runs in either role; the override doubles the event threshold.
  wire usb_over = high_mode ? (limit_override ? over_1000 : over_500)
                            : (limit_override ? over_200 : over_100);
  wire usb_in_use = ~usb_disconnect & (host_role_reg | (supply_reg == spc_pkg::SUP_USB));
  wire over_event = usb_in_use & usb_over;
  wire flag_read  = ar_take & r_stat;
  wire usb_charge = sel_usb_next & ~host_role_reg;
  wire trickle_ok = ~(~high_mode & over_100);
  wire fast_room  = ~high_mode | ~over_500;

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      over_prev_reg <= 1'b0;
      flag_reg      <= 1'b0;
    end else begin
      over_prev_reg <= over_event;
      // A new edge in the same cycle as the clearing read keeps the flag set.
      if (over_event && !over_prev_reg) begin
        flag_reg <= 1'b1;
      end else if (flag_read) begin
        flag_reg <= 1'b0;
      end
    end
  end

  // The fast level walks one step per cycle, trading speed for a simple loop.
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      level_reg <= '0;
    end else if (!(usb_charge && high_mode)) begin
      level_reg <= '1;
    end else if (over_500) begin
      if (level_reg != '0) begin
        level_reg <= level_reg - 1'b1;
      end
    end else if (fast_room && level_reg != '1) begin
      level_reg <= level_reg + 1'b1;
    end
  end

  // ****************************************************************************
  // Output flip-flops.
  // ****************************************************************************
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      SEL_WALL      <= 1'b0;
      SEL_USB       <= 1'b0;
      SEL_CELL      <= 1'b1;
      USB_SWITCH_ON <= 1'b0;
      USB_SOURCING  <= 1'b0;
      USB_LIMIT_ON  <= 1'b0;
      USB_HIGH_MODE <= 1'b0;
      WAKE_PERMIT   <= 1'b0;
      TRICKLE_EN    <= 1'b0;
      FAST_EN       <= 1'b0;
      FAST_LEVEL    <= '0;
      USB_IRQ       <= 1'b0;
    end else begin
      SEL_WALL      <= sel_wall_next;
      SEL_USB       <= sel_usb_next;
      SEL_CELL      <= supply_next == spc_pkg::SUP_CELL;
      USB_SWITCH_ON <= ~usb_disconnect & (sel_usb_next | host_role_reg);
      USB_SOURCING  <= host_role_reg & ~usb_disconnect;
      USB_LIMIT_ON  <= usb_in_use & ~limit_override;
      USB_HIGH_MODE <= high_mode;
      WAKE_PERMIT   <= wake_request & ~(sel_usb_next & ~usb_above_4v0);
      TRICKLE_EN    <= cell_ok & (sel_wall_next | (usb_charge & trickle_ok));
      FAST_EN       <= cell_ok & state_active & fast_request
                       & (sel_wall_next | (usb_charge & high_mode));
      FAST_LEVEL    <= level_reg;
      USB_IRQ       <= (flag_reg & ~flag_read) & ~flag_mask;
    end
  end

endmodule

//--- tb/spc_top_checker.sv
// Port assertions for the supply control block.
module spc_top_checker #(
  parameter int LEVEL_W = 4
) (
  // Clock and reset.
  input wire logic               CLOCK,
  input wire logic               NRST,
  // Comparator levels.
  input wire logic               WALL_IN_RANGE,
  input wire logic               WALL_HIGHEST,
  input wire logic               USB_PRESENT,
  input wire logic               USB_HIGHEST,
  input wire logic               USB_ABOVE_4V0,
  input wire logic               USB_OVER_100,
  // Controls.
  input wire logic               SEL_WALL,
  input wire logic               SEL_USB,
  input wire logic               SEL_CELL,
  input wire logic               USB_SWITCH_ON,
  input wire logic               USB_SOURCING,
  input wire logic               WAKE_PERMIT,
  input wire logic [LEVEL_W-1:0] FAST_LEVEL,
  input wire logic               USB_IRQ
);
  // ****
  // Helper count and assertions.
  // ****
  logic [3:0] since_over_reg;
  always_ff @(posedge CLOCK) begin
    if (!NRST) since_over_reg <= 4'hf;
    else if (USB_OVER_100) since_over_reg <= 4'h0;
    else if (since_over_reg != 4'hf) since_over_reg <= since_over_reg + 4'h1;
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  // Inputs pass two sync stages, so levels are held five cycles first.
  sel_onehot_a: assert property ($onehot({SEL_WALL, SEL_USB, SEL_CELL}))
    else $error("supply select not one-hot");
  wall_pick_a: assert property (WALL_IN_RANGE [*5] |-> SEL_WALL)
    else $error("wall in range not chosen");
  usb_pick_a: assert property ((!WALL_IN_RANGE && !WALL_HIGHEST && USB_PRESENT && USB_HIGHEST
    && USB_SWITCH_ON && !USB_SOURCING) [*5] |-> SEL_USB) else $error("usb not chosen");
  cut_switch_a: assert property (!USB_SWITCH_ON [*2] |-> !SEL_USB)
    else $error("usb chosen with switch open");
  host_nouse_a: assert property (USB_SOURCING [*2] |-> !SEL_USB)
    else $error("usb drawn while sourcing");
  fast_step_a: assert property (SEL_USB && $past(SEL_USB) |-> FAST_LEVEL == $past(FAST_LEVEL)
    || FAST_LEVEL == $past(FAST_LEVEL) + 1'b1 || FAST_LEVEL == $past(FAST_LEVEL) - 1'b1)
    else $error("fast level jumped");
  fast_full_a: assert property (!SEL_USB [*4] |-> &FAST_LEVEL)
    else $error("fast level trimmed off usb");
  wake_gate_a: assert property ((SEL_USB && !USB_ABOVE_4V0) [*5] |-> !WAKE_PERMIT)
    else $error("wake permitted on low usb");
  irq_cause_a: assert property ($rose(USB_IRQ) |-> since_over_reg < 4'ha)
    else $error("interrupt without over-current");
  cover property (SEL_USB ##1 SEL_WALL);
  cover property ($rose(USB_IRQ));
  cover property (USB_SOURCING);
endmodule

bind spc_top spc_top_checker #(.LEVEL_W(LEVEL_W)) chk (.*);

//--- tb/spc_supply_model.sv
// Behavioural wall adaptor, USB bus, cell and USB load around the block.
module spc_supply_model #(
  parameter int CELL_OK_MV  = 3000,
  parameter int USB_SEEN_MV = 1000
) (
  // Source voltages in millivolts and USB load in milliamps.
  input  int   wall_mv,
  input  int   usb_mv,
  input  int   cell_mv,
  input  int   load_ma,
  // Comparator levels.
  output logic wall_in_range,
  output logic wall_highest,
  output logic usb_present,
  output logic usb_highest,
  output logic usb_above_4v0,
  output logic cell_ok,
  output logic over_100,
  output logic over_200,
  output logic over_500,
  output logic over_1000
);
  assign wall_in_range = wall_mv >= 4000 && wall_mv <= 5500;
  assign wall_highest  = wall_mv > usb_mv && wall_mv > cell_mv;
  assign usb_present   = usb_mv >= USB_SEEN_MV;
  assign usb_highest   = usb_mv > wall_mv && usb_mv > cell_mv;
  assign usb_above_4v0 = usb_mv >= 4000;
  assign cell_ok       = cell_mv >= CELL_OK_MV;
  assign over_100      = load_ma > 100;
  assign over_200      = load_ma > 200;
  assign over_500      = load_ma > 500;
  assign over_1000     = load_ma > 1000;
endmodule

//--- tb/spc_top_tb.sv
// Self-checking bench for the supply control block.
module spc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Signals and model state.
  // ****
  logic        CLOCK = 1'b0, NRST = 1'b0, AWVALID = 1'b0, WVALID = 1'b0, ARVALID = 1'b0;
  logic        BREADY = 1'b1, RREADY = 1'b1, CONFIG_USB_HIGH = 1'b0, STATE_ACTIVE = 1'b1;
  logic        PREF_BELOW_UVLO = 1'b0, BOOT_HYST_FAIL = 1'b0, USB_ROLE_DROP = 1'b0;
  logic        WAKE_REQUEST = 1'b1, AWREADY, WREADY, BVALID, ARREADY, RVALID, USB_IRQ;
  logic        WALL_IN_RANGE, WALL_HIGHEST, USB_PRESENT, USB_HIGHEST, USB_ABOVE_4V0;
  logic        CELL_SUPPLY_PIN_OK, USB_OVER_100, USB_OVER_200, USB_OVER_500, USB_OVER_1000;
  logic        SEL_WALL, SEL_USB, SEL_CELL, USB_SWITCH_ON, USB_SOURCING, USB_LIMIT_ON;
  logic        USB_HIGH_MODE, WAKE_PERMIT, TRICKLE_EN, FAST_EN;
  logic [3:0]  WSTRB = 4'hf, FAST_LEVEL;
  logic [7:0]  AWADDR = 8'h00, ARADDR = 8'h00;
  logic [1:0]  BRESP, RRESP;
  logic [31:0] WDATA = 32'h0000_0000, RDATA, lfsr = 32'h0000_2e53;
  int          wall_mv = 0, usb_mv = 0, cell_mv = 3700, load_ma = 0, thr;
  int          num_errors = 0, checked = 0, cyc = 0, ctrl_m = 0;
  int          sw[5] = '{5000, 3500, 3000, 0, 5000}, su[5] = '{5200, 0, 5000, 3900, 5000};
  int          sc[5] = '{3700, 3300, 3700, 3700, 3700}, ld[3] = '{300, 700, 1200};
  int          cfg[4] = '{32'h0000_0000, 32'h0000_0200, 32'h0000_2000, 32'h0000_2800};

  spc_top #(.ADDR_W(8), .LEVEL_W(4)) uut (.*);
  spc_supply_model sup (.wall_mv(wall_mv), .usb_mv(usb_mv), .cell_mv(cell_mv), .load_ma(load_ma),
    .wall_in_range(WALL_IN_RANGE), .wall_highest(WALL_HIGHEST), .usb_present(USB_PRESENT),
    .usb_highest(USB_HIGHEST), .usb_above_4v0(USB_ABOVE_4V0), .cell_ok(CELL_SUPPLY_PIN_OK),
    .over_100(USB_OVER_100), .over_200(USB_OVER_200), .over_500(USB_OVER_500),
    .over_1000(USB_OVER_1000));

  initial begin
    forever #12.5 CLOCK = ~CLOCK;
  end
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
  end
  // ****
  // Tasks and model.
  // ****
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic spc_pkg::spc_supply_t exp_sel();
    if ((wall_mv >= 4000 && wall_mv <= 5500) || (wall_mv > usb_mv && wall_mv > cell_mv))
      return spc_pkg::SUP_WALL;
    if (ctrl_m[14:13] == 2'b00 && usb_mv >= 1000 && usb_mv > wall_mv && usb_mv > cell_mv)
      return spc_pkg::SUP_USB;
    return spc_pkg::SUP_CELL;
  endfunction
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    int n;
    n = 0;
    AWADDR <= a;
    WDATA <= {16'h0000, d};
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    do begin
      @(posedge CLOCK);
      n++;
      if (AWREADY === 1'b1) AWVALID <= 1'b0;
      if (WREADY === 1'b1) WVALID <= 1'b0;
    end while (BVALID !== 1'b1 && n < 50);
    chk({BVALID, BRESP}, {1'b1, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er);
    int n;
    n = 0;
    ARADDR <= a;
    ARVALID <= 1'b1;
    do begin
      @(posedge CLOCK);
      n++;
      if (ARREADY === 1'b1) ARVALID <= 1'b0;
    end while (RVALID !== 1'b1 && n < 50);
    chk({RVALID, RRESP, RDATA}, {1'b1, er, 16'h0000, e});
  endtask
  task automatic settle();
    repeat (6) @(posedge CLOCK);
    chk({SEL_USB, SEL_WALL, SEL_CELL}, exp_sel());
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ****
  // Scenarios.
  // ****
  initial begin
    repeat (12) @(posedge CLOCK);
    NRST <= 1'b1;
    @(posedge CLOCK);
    rd(8'h10, 16'h0000, 2'h0);
    rd(8'h88, 16'h0000, 2'h0);
    wr(8'h00, 16'hffff, 2'h2);
    rd(8'h00, 16'h0000, 2'h2);
    wr(8'h68, 16'h0400, 2'h0);
    rd(8'h68, 16'h0000, 2'h0);
    $display("done reset");
    for (int i = 0; i < 5; i++) begin
      wall_mv <= sw[i];
      usb_mv <= su[i];
      cell_mv <= sc[i];
      settle();
      if (exp_sel() == spc_pkg::SUP_WALL) chk(TRICKLE_EN, 1'b1);
    end
    $display("done supply choice");
    wall_mv <= 0;
    for (int k = 0; k < 2; k++) begin
      ctrl_m = 32'h0000_4000;
      wr(8'h10, 16'h4000, 2'h0);
      settle();
      chk(USB_SWITCH_ON, 1'b0);
      if (k == 0) PREF_BELOW_UVLO <= 1'b1;
      else BOOT_HYST_FAIL <= 1'b1;
      repeat (4) @(posedge CLOCK);
      PREF_BELOW_UVLO <= 1'b0;
      BOOT_HYST_FAIL <= 1'b0;
      ctrl_m = 0;
      rd(8'h10, 16'h0000, 2'h0);
      settle();
    end
    $display("done disconnect");
    for (int k = 0; k < 4; k++) begin
      lfsr = nx(lfsr);
      WAKE_REQUEST <= lfsr[3];
      wr(8'h88, lfsr[15:0], 2'h0);
      rd(8'h88, lfsr[15:0] & 16'h0400, 2'h0);
      chk(WAKE_PERMIT, lfsr[3]);
    end
    wr(8'h88, 16'h0000, 2'h0);
    for (int c = 0; c < 8; c++) begin
      for (int l = 0; l < 3; l++) begin
        ctrl_m = cfg[c % 4];
        wr(8'h10, ctrl_m[15:0], 2'h0);
        wr(8'hc0, {14'h0000, c[2], 1'b0}, 2'h0);
        thr = (ctrl_m[13] ? (ctrl_m[11] ? 500 : 100) : (ctrl_m[9] ? 500 : 100)) * (c[2] ? 2 : 1);
        load_ma <= ld[l];
        repeat (8) @(posedge CLOCK);
        chk({USB_IRQ, USB_HIGH_MODE, USB_LIMIT_ON},
            {ld[l] > thr, thr % 500 == 0, !c[2]});
        if (c % 4 == 0) chk(TRICKLE_EN, 1'b0);
        if (c % 4 >= 2) chk({TRICKLE_EN, FAST_EN}, 2'b00);
        rd(8'h68, (ld[l] > thr) ? 16'h0400 : 16'h0000, 2'h0);
        rd(8'h68, 16'h0000, 2'h0);
        load_ma <= 0;
        USB_ROLE_DROP <= 1'b1;
        repeat (4) @(posedge CLOCK);
        USB_ROLE_DROP <= 1'b0;
        rd(8'h10, ctrl_m[15:0] & 16'hdfff, 2'h0);
        ctrl_m = 0;
      end
    end
    $display("done over-current");
    wr(8'h10, 16'h0000, 2'h0);
    wr(8'h88, 16'h0400, 2'h0);
    load_ma <= 300;
    repeat (8) @(posedge CLOCK);
    chk(USB_IRQ, 1'b0);
    rd(8'h68, 16'h0400, 2'h0);
    load_ma <= 0;
    $display("done mask");
    end_sim();
  end
endmodule
